// ==== core/tsic_core.sv ====
// Purpose: three-source interrupt controller for a small 8-bit core
// Assumes: core gives instruction-boundary strobe and phase-two pulse
// Notes:   flags live in the interrupt control byte at data address 0x0B
//
// Operation
// [R01] falling edge on external pin sets external request flag, bit 4
// [R02] pending, enabled external request with stack room calls vector 04H
// [R03] accepting external request clears its flag and the global enable
// [R04] timer overflow sets timer request flag, bit 5
// [R05] accepted timer request calls 08H, clears its flag and global enable
// [R06] conversion done sets converter request flag, bit 6
// [R07] accepted converter request calls 0CH, clears flag and global enable
// [R08] no acceptance in service until return-with-enable or software re-enables
// [R09] return-with-enable sets global enable; plain return leaves it alone
// [R10] request between two phase-two pulses is taken at the later pulse
// [R11] fixed priority external, timer, converter; global enable masks all
// [R12] enables: global bit 0, external 1, timer 2, converter 3; one enables
// [R13] bit 7 reads zero
// [R14] control byte sits at data address 0BH, ordinary read and write
// [R15] enables gate service only, never the setting of a flag
// [R16] flags stay set until serviced or cleared by software
// [R17] full stack holds off acceptance; flag stays pending
// [R18] only program counter is pushed; status is not saved
// [R19] software writing one to a flag makes a real pending request
// [R20] acceptance only at an instruction boundary, replacing next fetch
`timescale 1ns/1ns
module tsic_core
	import tsic_pkg::*;
#(
	parameter int VEC_W = 11
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// event sources
	input  wire logic             ext_irq_pin_n,
	input  wire logic             timer_overflow,
	input  wire logic             conv_done,
	// core timing
	input  wire logic             phase_two_pulse,
	input  wire logic             instr_boundary,
	input  wire logic             stack_full,
	input  wire logic             return_with_enable,
	// data memory access
	input  wire logic [7:0]       mem_addr,
	input  wire logic             mem_wr,
	input  wire logic [7:0]       mem_wdata,
	output logic [7:0]            mem_rdata,
	output logic                  mem_hit,
	// to the sequencer
	output logic                  irq_call,
	output logic [VEC_W-1:0]      irq_vector,
	output logic                  push_pc_only
);
	// refuse a vector too narrow to hold the highest vector
	if (VEC_W < 4) begin : g_vec_w_bad
		$error("vector width too small");
	end

	// ****************************************
	// pin synchroniser
	// ****************************************
	logic ext_fall;
	tsic_sync u_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.pin     (ext_irq_pin_n),
		.level   (),
		.fall    (ext_fall)
	);

	// ****************************************
	// register decode
	// ****************************************
	logic [7:0]  ctrl_r;
	logic [7:0]  ctrl_nxt;
	logic [2:0]  cand_r;
	logic [2:0]  cand_nxt;
	tsic_state_t state_r;
	tsic_state_t state_nxt;

	wire        reg_sel   = (mem_addr == INTERRUPT_CONTROL_ADDR); // [R14]
	wire        reg_wr    = reg_sel & mem_wr;
	wire        wr_glob   = mem_wdata[BIT_GLOBAL_EN];
	wire [2:0]  flags     = ctrl_r[BIT_CONV_FLAG:BIT_EXT_FLAG];
	wire [2:0]  enables   = ctrl_r[BIT_CONV_EN:BIT_EXT_EN];
	wire        glob_en   = ctrl_r[BIT_GLOBAL_EN];
	// enables gate only the service path, never the flags
	wire [2:0]  ready     = flags & enables & {3{glob_en}}; // [R11] [R15]

	function automatic logic [2:0] pick(input logic [2:0] req);
		if (req[0]) begin
			pick = SRC_EXT;
		end else if (req[1]) begin
			pick = SRC_TMR;
		end else if (req[2]) begin
			pick = SRC_CONV;
		end else begin
			pick = SRC_NONE;
		end
	endfunction

	function automatic logic [10:0] vec_of(input logic [2:0] src);
		case (src)
			SRC_EXT:  vec_of = VEC_EXT;
			SRC_TMR:  vec_of = VEC_TMR;
			SRC_CONV: vec_of = VEC_CONV;
			default:  vec_of = VEC_NONE;
		endcase
	endfunction

	wire [2:0]  winner    = pick(ready); // [R11]
	// taken only at a boundary with stack room; a full stack just waits
	wire        accept    = (state_r == ST_TAKE) & instr_boundary
	                        & ~stack_full & (pick(ready & cand_r) != SRC_NONE); // [R17] [R20]
	wire [2:0]  take_src  = pick(ready & cand_r);

	// ****************************************
	// event sources
	// ****************************************
	wire        ext_set   = ext_fall;       // [R01]
	wire        tmr_set   = timer_overflow; // [R04]
	wire        conv_set  = conv_done;      // [R06]
	wire [2:0]  hw_set    = {conv_set, tmr_set, ext_set}; // [R01] [R04] [R06]

	// ****************************************
	// control byte next value
	// ****************************************
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (reg_wr) begin
			// software may set a flag, which then acts like a hardware event
			ctrl_nxt = mem_wdata & CTRL_WMASK; // [R13] [R19] [R12]
		end
		if (accept) begin
			ctrl_nxt[BIT_GLOBAL_EN] = 1'b0; // [R03] [R05] [R07] [R08]
			ctrl_nxt[BIT_CONV_FLAG:BIT_EXT_FLAG] =
				ctrl_nxt[BIT_CONV_FLAG:BIT_EXT_FLAG] & ~take_src; // [R03] [R05] [R07]
		end
		if (return_with_enable) begin
			ctrl_nxt[BIT_GLOBAL_EN] = 1'b1; // [R09]
		end
		// set beats clear so no event is lost
		ctrl_nxt[BIT_CONV_FLAG:BIT_EXT_FLAG] =
			ctrl_nxt[BIT_CONV_FLAG:BIT_EXT_FLAG] | hw_set; // [R16]
	end

	// ****************************************
	// checks: flags and enables
	// ****************************************
	chk_ext_fall_sets: assert property (@(posedge clk) disable iff (!reset_n) // [R01]
		ext_fall
		|=> ctrl_r[BIT_EXT_FLAG])
		else $error("external fall did not set its flag");

	chk_conv_done_sets: assert property (@(posedge clk) disable iff (!reset_n) // [R06]
		conv_done
		|=> ctrl_r[BIT_CONV_FLAG])
		else $error("conversion done did not set its flag");

	chk_ext_flag_cause: assert property (@(posedge clk) disable iff (!reset_n) // [R19]
		$rose(ctrl_r[BIT_EXT_FLAG])
		|-> $past(ext_fall) || $past(reg_wr))
		else $error("external flag rose without cause");

	chk_tmr_flag_cause: assert property (@(posedge clk) disable iff (!reset_n) // [R04]
		$rose(ctrl_r[BIT_TMR_FLAG])
		|-> $past(timer_overflow) || $past(reg_wr))
		else $error("timer flag rose without cause");

	chk_conv_flag_cause: assert property (@(posedge clk) disable iff (!reset_n) // [R06]
		$rose(ctrl_r[BIT_CONV_FLAG])
		|-> $past(conv_done) || $past(reg_wr))
		else $error("converter flag rose without cause");

	chk_ext_cleared: assert property (@(posedge clk) disable iff (!reset_n) // [R03]
		accept && take_src == SRC_EXT && !ext_fall
		|=> !ctrl_r[BIT_EXT_FLAG])
		else $error("external flag kept after call");

	chk_tmr_cleared: assert property (@(posedge clk) disable iff (!reset_n) // [R05]
		accept && take_src == SRC_TMR && !timer_overflow
		|=> !ctrl_r[BIT_TMR_FLAG])
		else $error("timer flag kept after call");

	chk_conv_cleared: assert property (@(posedge clk) disable iff (!reset_n) // [R07]
		accept && take_src == SRC_CONV && !conv_done
		|=> !ctrl_r[BIT_CONV_FLAG])
		else $error("converter flag kept after call");

	chk_pending_full: assert property (@(posedge clk) disable iff (!reset_n) // [R17]
		stack_full && ctrl_r[BIT_EXT_FLAG] && !reg_wr
		|=> ctrl_r[BIT_EXT_FLAG])
		else $error("pending flag lost while stack full");

	chk_glob_hold: assert property (@(posedge clk) disable iff (!reset_n) // [R08]
		!glob_en && !return_with_enable && !reg_wr
		|=> !ctrl_r[BIT_GLOBAL_EN])
		else $error("global enable came back on its own");

	chk_write_glob: assert property (@(posedge clk) disable iff (!reset_n) // [R12]
		reg_wr && !accept && !return_with_enable
		|=> ctrl_r[BIT_GLOBAL_EN] == $past(wr_glob))
		else $error("global enable write did not land");

	// ****************************************
	// phase-two sampling
	// ****************************************
	// candidates latch at a phase-two pulse; they are served at the first instruction boundary with stack room
	always_comb begin
		state_nxt = state_r;
		cand_nxt  = cand_r;
		case (state_r)
			ST_IDLE: begin
				if (phase_two_pulse && ready != SRC_NONE) begin
					state_nxt = ST_TAKE; // [R10]
					cand_nxt  = ready;
				end
			end
			ST_TAKE: begin
				if (accept) begin
					state_nxt = ST_HOLD;
				end else if (ready == SRC_NONE) begin
					state_nxt = ST_IDLE;
				end else if (phase_two_pulse) begin
					cand_nxt = ready;
				end
			end
			ST_HOLD: begin
				state_nxt = ST_IDLE;
				cand_nxt  = SRC_NONE;
			end
			default: begin
				state_nxt = ST_IDLE;
				cand_nxt  = SRC_NONE;
			end
		endcase
	end

	// ****************************************
	// checks: sampling and priority
	// ****************************************
	chk_take_after_pulse: assert property (@(posedge clk) disable iff (!reset_n) // [R10]
		state_r == ST_TAKE && $past(state_r) == ST_IDLE
		|-> $past(phase_two_pulse))
		else $error("candidate latched without phase-two pulse");

	chk_prio_ext_first: assert property (@(posedge clk) disable iff (!reset_n) // [R11]
		accept && (flags & cand_r & SRC_EXT) != SRC_NONE
		|=> irq_vector == VEC_W'(VEC_EXT))
		else $error("external request lost priority");

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r  <= CTRL_RESET;
			state_r <= ST_IDLE;
			cand_r  <= SRC_NONE;
		end else begin
			ctrl_r  <= ctrl_nxt;
			state_r <= state_nxt;
			cand_r  <= cand_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	logic [VEC_W-1:0] vec_r;
	logic             call_r;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			vec_r  <= '0;
			call_r <= 1'b0;
		end else begin
			call_r <= accept; // [R02] [R05] [R07]
			if (accept) begin
				vec_r <= VEC_W'(vec_of(take_src));
			end
		end
	end

	assign irq_call     = call_r;
	assign irq_vector   = vec_r;
	// status byte is never stacked by the controller
	assign push_pc_only = call_r; // [R18]
	assign mem_hit      = reg_sel;
	assign mem_rdata    = reg_sel ? (ctrl_r & CTRL_WMASK) : 8'h00; // [R13]

	// ****************************************
	// checks: outputs
	// ****************************************
	chk_call_pulse: assert property (@(posedge clk) disable iff (!reset_n) // [R20]
		irq_call
		|=> !irq_call)
		else $error("call pulse longer than one cycle");

	chk_vec_stable: assert property (@(posedge clk) disable iff (!reset_n) // [R02]
		!irq_call
		|-> $stable(irq_vector))
		else $error("vector moved without a call");

	chk_other_addr: assert property (@(posedge clk) disable iff (!reset_n) // [R14]
		!mem_hit
		|-> mem_rdata == 8'h00)
		else $error("read data on a foreign address");

	chk_read_bit7: assert property (@(posedge clk) disable iff (!reset_n) // [R13]
		mem_hit
		|-> !mem_rdata[7])
		else $error("bit 7 read back as one");

	// ****************************************
	// checks
	// ****************************************
	chk_bit7_zero: assert property (@(posedge clk) disable iff (!reset_n) // [R13]
		!ctrl_r[7])
		else $error("bit 7 of control byte set");
	chk_call_clears_glob: assert property (@(posedge clk) disable iff (!reset_n) // [R03]
		accept && !return_with_enable |=> !ctrl_r[BIT_GLOBAL_EN] && irq_call)
		else $error("global enable not cleared on call");
	chk_ext_vector: assert property (@(posedge clk) disable iff (!reset_n) // [R02]
		accept && take_src == SRC_EXT |=> irq_vector == VEC_W'(VEC_EXT))
		else $error("wrong external vector");
	chk_tmr_vector: assert property (@(posedge clk) disable iff (!reset_n) // [R05]
		accept && take_src == SRC_TMR |=> irq_vector == VEC_W'(VEC_TMR))
		else $error("wrong timer vector");
	chk_conv_vector: assert property (@(posedge clk) disable iff (!reset_n) // [R07]
		accept && take_src == SRC_CONV |=> irq_vector == VEC_W'(VEC_CONV))
		else $error("wrong converter vector");
	chk_full_stack: assert property (@(posedge clk) disable iff (!reset_n) // [R17]
		stack_full |=> !irq_call)
		else $error("call taken with full stack");
	chk_return_with_enable_sets: assert property (@(posedge clk) disable iff (!reset_n) // [R09]
		return_with_enable |=> ctrl_r[BIT_GLOBAL_EN])
		else $error("return with enable did not enable");
	chk_flag_sticky: assert property (@(posedge clk) disable iff (!reset_n) // [R16]
		timer_overflow |=> ctrl_r[BIT_TMR_FLAG])
		else $error("timer flag lost");
	chk_boundary_only: assert property (@(posedge clk) disable iff (!reset_n) // [R20]
		!$past(instr_boundary) |-> !irq_call)
		else $error("call away from boundary");
endmodule

// ==== inc/tsic_pkg.sv ====
// Purpose: constants for the three-source interrupt controller
// Assumes: 8-bit data memory bus, 11-bit program addresses
// Notes:   one register, the interrupt control byte
package tsic_pkg;
	localparam logic [7:0]  INTERRUPT_CONTROL_ADDR      = 8'h0B;
	localparam int          BIT_GLOBAL_EN  = 0;
	localparam int          BIT_EXT_EN     = 1;
	localparam int          BIT_TMR_EN     = 2;
	localparam int          BIT_CONV_EN    = 3;
	localparam int          BIT_EXT_FLAG   = 4;
	localparam int          BIT_TMR_FLAG   = 5;
	localparam int          BIT_CONV_FLAG  = 6;
	localparam logic [7:0]  CTRL_RESET     = 8'h00;
	localparam logic [7:0]  CTRL_WMASK     = 8'h7F;
	localparam logic [10:0] VEC_EXT        = 11'h004;
	localparam logic [10:0] VEC_TMR        = 11'h008;
	localparam logic [10:0] VEC_CONV       = 11'h00C;
	localparam logic [10:0] VEC_NONE       = 11'h000;
	localparam logic [2:0]  SRC_EXT        = 3'b001;
	localparam logic [2:0]  SRC_TMR        = 3'b010;
	localparam logic [2:0]  SRC_CONV       = 3'b100;
	localparam logic [2:0]  SRC_NONE       = 3'b000;
	localparam logic [2:0]  PIN_HIGH3      = 3'b111;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_TAKE = 3'b010,
		ST_HOLD = 3'b100
	} tsic_state_t;
endpackage

// ==== core/tsic_sync.sv ====
// Purpose: three-stage synchroniser with agreement filter for a pin
// Assumes: pin is asynchronous to clk
// Notes:   first stage is read only by the second
`timescale 1ns/1ns
module tsic_sync
	import tsic_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// pin and result
	input  wire logic pin,
	output logic      level,
	output logic      fall
);
	logic [2:0] stage_r;
	logic       level_r;
	wire        agree = (stage_r[1] == stage_r[2]);
	wire        level_nxt = agree ? stage_r[2] : level_r;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stage_r <= PIN_HIGH3;
			level_r <= 1'b1;
		end else begin
			stage_r <= {stage_r[1:0], pin};
			level_r <= level_nxt;
		end
	end

	assign level = level_r;
	// one pulse when the filtered level drops
	assign fall = level_r & ~level_nxt;
endmodule

// ==== verif/tsic_seq_model.sv ====
// Purpose: sequencer and call stack seen by the controller
// Assumes: one instruction every four clocks
// Notes:   returns are requested by the bench
`timescale 1ns/1ns
module tsic_seq_model #(
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// bench requests
	input  wire logic pop,
	input  wire logic pop_en,
	// controller side
	input  wire logic irq_call,
	output logic      phase_two_pulse,
	output logic      instr_boundary,
	output logic      stack_full,
	output logic      return_with_enable
);
	// ****************************************
	// timing and stack
	// ****************************************
	logic [1:0] cnt_r;
	int         depth_r;
	assign phase_two_pulse    = (cnt_r == 2'h0);
	assign instr_boundary     = (cnt_r == 2'h1);
	assign stack_full         = (depth_r >= DEPTH);
	assign return_with_enable = pop & pop_en;
	// small depth so a full stack is cheap to reach
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= 2'h0;
			depth_r <= 0;
		end else begin
			cnt_r <= cnt_r + 2'h1;
			depth_r <= depth_r + int'(irq_call) - int'(pop);
		end
	end
endmodule

// ==== verif/test_three_source_interrupt_controller.sv ====
// Purpose: self-checking bench for the interrupt controller
// Assumes: stack model two deep
// Notes:   inputs change on the falling edge
`timescale 1ns/1ns
module test_three_source_interrupt_controller;
	import tsic_pkg::*;
	logic        clk, reset_n, pin_n, tmr_ov, cdone, pop, pop_en;
	logic        p2, ib, sfull, rwe, mem_wr, mem_hit, irq_call, push_only;
	logic [7:0]  mem_addr, mem_wdata, mem_rdata;
	logic [10:0] irq_vector;
	int          miscompares = 0;
	int          check_count = 0;
	tsic_core tsic_core_i (.clk(clk), .reset_n(reset_n), .ext_irq_pin_n(pin_n),
		.timer_overflow(tmr_ov), .conv_done(cdone), .phase_two_pulse(p2),
		.instr_boundary(ib), .stack_full(sfull), .return_with_enable(rwe),
		.mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_hit(mem_hit), .irq_call(irq_call),
		.irq_vector(irq_vector), .push_pc_only(push_only));
	tsic_seq_model tsic_seq_model_i (.clk(clk), .reset_n(reset_n), .pop(pop),
		.pop_en(pop_en), .irq_call(irq_call), .phase_two_pulse(p2),
		.instr_boundary(ib), .stack_full(sfull), .return_with_enable(rwe));
	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(string nm, logic [10:0] exp, logic [10:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(negedge clk) {mem_addr, mem_wdata, mem_wr} = {a, d, 1'b1};
		@(negedge clk) mem_wr = 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] exp);
		@(negedge clk) mem_addr = a;
		#1 chk("mem_rdata", {3'h0, exp}, {3'h0, mem_rdata});
		chk("mem_hit", {10'h0, a == INTERRUPT_CONTROL_ADDR}, {10'h0, mem_hit});
	endtask
	task automatic wait_call(logic [10:0] v);
		int n;
		for (n = 0; n < 40 && irq_call !== 1'b1; n++) @(negedge clk);
		chk("irq_call", 11'h1, {10'h0, irq_call});
		chk("irq_vector", v, irq_vector);
		chk("push_pc_only", 11'h1, {10'h0, push_only});
		@(negedge clk);
	endtask
	task automatic no_call(int n);
		repeat (n) begin
			@(negedge clk) chk("irq_call", 11'h0, {10'h0, irq_call});
			chk("push_pc_only", 11'h0, {10'h0, push_only});
		end
	endtask
	task automatic ret(logic en);
		@(negedge clk) {pop, pop_en} = {1'b1, en};
		@(negedge clk) {pop, pop_en} = 2'b00;
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ****************************************
	// clock, reset, watchdog
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#200000 miscompares++;
		print_verdict();
	end
	// ****************************************
	// tests
	// ****************************************
	initial begin
		{pin_n, tmr_ov, cdone, pop, pop_en, mem_wr} = 6'b100000;
		{mem_addr, mem_wdata, reset_n} = 17'h0;
		repeat (5) @(negedge clk);
		reset_n = 1'b1;
		rd(INTERRUPT_CONTROL_ADDR, 8'h00);
		rd(8'h0C, 8'h00);
		wr(INTERRUPT_CONTROL_ADDR, 8'hFE);
		rd(INTERRUPT_CONTROL_ADDR, 8'h7E);
		no_call(20);
		wr(INTERRUPT_CONTROL_ADDR, 8'h7F);
		wait_call(VEC_EXT);
		rd(INTERRUPT_CONTROL_ADDR, 8'h6E);
		no_call(20);
		ret(1'b1);
		wait_call(VEC_TMR);
		rd(INTERRUPT_CONTROL_ADDR, 8'h4E);
		ret(1'b1);
		wait_call(VEC_CONV);
		rd(INTERRUPT_CONTROL_ADDR, 8'h0E);
		ret(1'b1);
		rd(INTERRUPT_CONTROL_ADDR, 8'h0F);
		// events with every enable off
		wr(INTERRUPT_CONTROL_ADDR, 8'h00);
		@(negedge clk) {tmr_ov, cdone, pin_n} = 3'b110;
		@(negedge clk) {tmr_ov, cdone} = 2'b00;
		repeat (6) @(negedge clk);
		pin_n = 1'b1;
		repeat (6) @(negedge clk);
		rd(INTERRUPT_CONTROL_ADDR, 8'h70);
		no_call(12);
		rd(INTERRUPT_CONTROL_ADDR, 8'h70);
		// fill the stack, then hold off
		wr(INTERRUPT_CONTROL_ADDR, 8'h13);
		wait_call(VEC_EXT);
		wr(INTERRUPT_CONTROL_ADDR, 8'h13);
		wait_call(VEC_EXT);
		wr(INTERRUPT_CONTROL_ADDR, 8'h13);
		no_call(20);
		rd(INTERRUPT_CONTROL_ADDR, 8'h13);
		ret(1'b0);
		wait_call(VEC_EXT);
		ret(1'b0);
		@(negedge clk) tmr_ov = 1'b1;
		@(negedge clk) tmr_ov = 1'b0;
		no_call(12);
		rd(INTERRUPT_CONTROL_ADDR, 8'h22);
		// reset in mid-run clears vector and control byte
		@(negedge clk) reset_n = 1'b0;
		@(negedge clk) chk("irq_vector", 11'h000, irq_vector);
		reset_n = 1'b1;
		repeat (4) @(negedge clk);
		rd(INTERRUPT_CONTROL_ADDR, 8'h00);
		no_call(8);
		print_verdict();
	end
endmodule
